// ---- core/epp_ecp_parallel_port.sv ----
// Multi-mode parallel port: register map, EPP cycles, ECP/compat FIFO transfers.
//
// Functional notes
// - EPP idle: control register drives lines, direction
// - Abort EPP cycle after 10 us wait
// - Timeout sets status bit 0
// - Address cycle selects, data cycles follow
// - Four EPP cycles, address/data strobes
// - New variant: strobe while wait low
// - New variant: hold off while wait high
// - Old variant: start blind, end on rise
// - One shared 16-byte FIFO, both directions
// - DMA in forward and reverse ECP
// - Run-length expand received ECP data
// - Compatibility handshake done in hardware
// - Mode from extended control bits 7-5
// - EPP mode needs chip option enable
// - Base-relative register decode
// - Data latch drives lines, read pins
// - Address FIFO byte tagged, forward only
// - Status: inverted busy, inputs, ones
// - Write one clears timeout flag
// - Modes 000/010 ignore direction bit
// - Configuration A reads constant 10h
`default_nettype none
module epp_ecp_parallel_port (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Host I/O access, request held until io_ack
   input wire pp_pkg::io_req_t io_req,
   input wire logic [15:0] io_base,
   output logic [7:0] io_rdata,
   output logic io_ack,
   // DMA channel
   output logic dma_req,
   input wire logic dma_ack,
   input wire logic [7:0] dma_wdata,
   output logic [7:0] dma_rdata,
   // Chip options
   input wire logic epp_option_en,
   input wire logic epp_v19_sel,
   // Cable side
   input wire logic [7:0] port_data_lines_in,
   output logic [7:0] port_data_lines_out,
   output logic port_data_lines_oe,
   input wire pp_pkg::peer_in_t peer,
   output pp_pkg::lines_t lines
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      pp_pkg::state_t st;
      logic [7:0] pd;
      logic pd_oe;
      logic [5:0] ctl;
      logic [2:0] mode;
      logic [2:0] ecr_lo;
      logic [2:0] cfgb;
      logic cycle_timeout_flag;
      logic [pp_pkg::FIFO_AW:0] wp;
      logic [pp_pkg::FIFO_AW:0] rp;
      logic avail;
      logic [9:0] wdog;
      logic hold_seen;
      logic is_addr;
      logic is_read;
      logic tag;
      logic [6:0] rle;
      logic [7:0] rx;
      logic rx_cmd;
      logic [5:0] tcnt;
      logic [7:0] rdata;
      logic ack;
      pp_pkg::lines_t lines;
   } state_s_t;

   state_s_t s_r;
   state_s_t s_nxt;
   logic mem_we;
   logic [pp_pkg::FIFO_W-1:0] mem_wd;
   logic [pp_pkg::FIFO_W-1:0] mem_rd;

   pp_fifo_mem u_fifo (
      .mclk(mclk),
      .we(mem_we),
      .waddr(s_r.wp[pp_pkg::FIFO_AW-1:0]),
      .wdata(mem_wd),
      .raddr(s_r.rp[pp_pkg::FIFO_AW-1:0]),
      .rdata(mem_rd)
   );

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   pp_pkg::mode_t mode;
   logic [15:0] off;
   logic eff_epp;
   logic full;
   logic empty;
   logic fwd;
   logic rev;
   logic epp_busy;
   logic take;
   logic fifo_host;

   assign mode = pp_pkg::mode_t'(s_r.mode);
   assign off = io_req.addr - io_base;
   assign eff_epp = (mode == pp_pkg::MODE_EPP) && epp_option_en;
   assign full = (s_r.wp[pp_pkg::FIFO_AW] != s_r.rp[pp_pkg::FIFO_AW]) &&
                 (s_r.wp[pp_pkg::FIFO_AW-1:0] == s_r.rp[pp_pkg::FIFO_AW-1:0]);
   assign empty = (s_r.wp == s_r.rp);
   assign fwd = (mode == pp_pkg::MODE_COMPAT_DATA_FIFO) || ((mode == pp_pkg::MODE_ECP) && !s_r.ctl[pp_pkg::CTL_DIR_BIT]);
   assign rev = (mode == pp_pkg::MODE_ECP) && s_r.ctl[pp_pkg::CTL_DIR_BIT];
   assign epp_busy = (s_r.st == pp_pkg::S_EPP_HOLD) || (s_r.st == pp_pkg::S_EPP_ACT);
   assign fifo_host = fwd || rev || (mode == pp_pkg::MODE_TEST);
   // A FIFO read waits until the registered read data is fresh
   assign take = (io_req.rd || io_req.wr) && !s_r.ack && !epp_busy &&
                 !(io_req.rd && off == pp_pkg::OFF_FIFO && fifo_host && !empty && !s_r.avail);
   // DMA is a combinational handshake; host access wins a shared cycle
   assign dma_req = s_r.ecr_lo[1] && ((fwd && !full) || (rev && !empty && s_r.avail));

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic pop;
      logic dacc;
      pop = 1'b0;
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      mem_we = 1'b0;
      mem_wd = '0;
      dacc = dma_req && dma_ack && !take;

      // Host register access, one-cycle answer except EPP cycles
      if (take) begin
         s_nxt.ack = 1'b1;
         s_nxt.rdata = 8'h00;
         if (off == pp_pkg::OFF_DATA) begin
            if (mode == pp_pkg::MODE_SPP || mode == pp_pkg::MODE_BIDIR || eff_epp) begin
               if (io_req.wr) begin
                  s_nxt.pd = io_req.wdata;
               end
               s_nxt.rdata = port_data_lines_in;
            end else if (mode == pp_pkg::MODE_ECP && io_req.wr && !rev && !full) begin
               mem_we = 1'b1;
               mem_wd = {1'b1, io_req.wdata};
            end
         end else if (off == pp_pkg::OFF_STATUS) begin
            if (io_req.wr && io_req.wdata[pp_pkg::STAT_CYCLE_TIMEOUT_FLAG_BIT]) begin
               s_nxt.cycle_timeout_flag = 1'b0;
            end
            // Timeout bit is only meaningful in EPP mode
            s_nxt.rdata = {~peer.peer_hold_n, peer.peer_acknowledge_n, peer.paper_error_in,
                           peer.select_in, peer.peer_fault_n, pp_pkg::ONES2,
                           eff_epp ? s_r.cycle_timeout_flag : 1'b1};
         end else if (off == pp_pkg::OFF_CONTROL) begin
            if (io_req.wr) begin
               s_nxt.ctl = io_req.wdata[5:0];
            end
            s_nxt.rdata = {pp_pkg::CTL_RSVD_READ, s_r.ctl};
         end else if (off >= pp_pkg::OFF_EPP_ADDR && off <= pp_pkg::OFF_EPP_DATA3 && eff_epp) begin
            // Launch one of the four EPP cycles; answer comes at its end
            s_nxt.ack = 1'b0;
            s_nxt.is_addr = (off == pp_pkg::OFF_EPP_ADDR);
            s_nxt.is_read = io_req.rd;
            if (io_req.wr) begin
               s_nxt.pd = io_req.wdata;
            end
            s_nxt.wdog = '0;
            s_nxt.hold_seen = 1'b0;
            s_nxt.st = epp_v19_sel ? pp_pkg::S_EPP_HOLD : pp_pkg::S_EPP_ACT;
         end else if (off == pp_pkg::OFF_FIFO) begin
            if (mode == pp_pkg::MODE_CONFIG) begin
               s_nxt.rdata = pp_pkg::CFGA_VALUE;
            end else if (fifo_host) begin
               if (io_req.wr && !rev && !full) begin
                  mem_we = 1'b1;
                  mem_wd = {1'b0, io_req.wdata};
               end
               if (io_req.rd && !fwd && !empty) begin
                  pop = 1'b1;
                  s_nxt.rdata = mem_rd[7:0];
               end
            end
         end else if (off == pp_pkg::OFF_CFGB) begin
            if (mode == pp_pkg::MODE_CONFIG) begin
               if (io_req.wr) begin
                  s_nxt.cfgb = io_req.wdata[pp_pkg::CFGB_IRQ_LSB +: 3];
               end
               s_nxt.rdata = {2'h0, s_r.cfgb, pp_pkg::ONES3};
            end
         end else if (off == pp_pkg::OFF_ECR) begin
            if (io_req.wr) begin
               s_nxt.mode = io_req.wdata[pp_pkg::ECR_MODE_LSB +: 3];
               s_nxt.ecr_lo = io_req.wdata[4:2];
               // Falling back to a plain mode discards queued bytes
               if (io_req.wdata[7:6] == 2'h0) begin
                  s_nxt.wp = '0;
                  s_nxt.rp = '0;
               end
            end
            s_nxt.rdata = {s_r.mode, s_r.ecr_lo, full, empty};
         end
      end

      // DMA data moves through the same FIFO
      if (dacc) begin
         if (fwd) begin
            mem_we = 1'b1;
            mem_wd = {1'b0, dma_wdata};
         end else begin
            pop = 1'b1;
            s_nxt.rdata = mem_rd[7:0];
         end
      end

      // Transfer sequencer
      unique case (s_r.st)
         pp_pkg::S_IDLE: begin
            if (fwd && !empty && s_r.avail && !pop) begin
               s_nxt.pd = mem_rd[7:0];
               s_nxt.tag = mem_rd[8];
               pop = 1'b1;
               s_nxt.tcnt = '0;
               s_nxt.st = pp_pkg::S_FWD_SET;
            end else if (rev && !peer.peer_acknowledge_n && !full) begin
               // Peripheral clock low: latch byte, busy low marks a command
               s_nxt.rx = port_data_lines_in;
               s_nxt.rx_cmd = !peer.peer_hold_n;
               s_nxt.st = pp_pkg::S_REV_ACK;
            end
         end
         pp_pkg::S_FWD_SET: begin
            s_nxt.tcnt = s_r.tcnt + 6'h01;
            if (s_r.tcnt == pp_pkg::STB_LAST) begin
               s_nxt.tcnt = '0;
               s_nxt.st = pp_pkg::S_FWD_STB;
            end
         end
         pp_pkg::S_FWD_STB: begin
            if (s_r.tcnt != pp_pkg::STB_LAST) begin
               s_nxt.tcnt = s_r.tcnt + 6'h01;
            end
            // ECP waits for busy to rise; compat holds the strobe 0.5 us
            if ((mode == pp_pkg::MODE_ECP) ? peer.peer_hold_n : (s_r.tcnt == pp_pkg::STB_LAST)) begin
               s_nxt.st = pp_pkg::S_FWD_REL;
            end
         end
         pp_pkg::S_FWD_REL: begin
            if (!peer.peer_hold_n) begin
               s_nxt.st = pp_pkg::S_IDLE;
            end
         end
         pp_pkg::S_REV_ACK: begin
            if (peer.peer_acknowledge_n) begin
               if (s_r.rx_cmd && !s_r.rx[7]) begin
                  s_nxt.rle = s_r.rx[6:0];
                  s_nxt.st = pp_pkg::S_IDLE;
               end else begin
                  s_nxt.st = pp_pkg::S_REV_PUSH;
               end
            end
         end
         pp_pkg::S_REV_PUSH: begin
            if (!full) begin
               mem_we = 1'b1;
               mem_wd = {s_r.rx_cmd, s_r.rx};
               // Data byte is written count plus one times
               if (s_r.rx_cmd || s_r.rle == 7'h00) begin
                  s_nxt.st = pp_pkg::S_IDLE;
               end else begin
                  s_nxt.rle = s_r.rle - 7'h01;
               end
            end
         end
         pp_pkg::S_EPP_HOLD: begin
            s_nxt.wdog = s_r.wdog + 10'h001;
            if (!peer.peer_hold_n) begin
               s_nxt.st = pp_pkg::S_EPP_ACT;
            end
         end
         pp_pkg::S_EPP_ACT: begin
            s_nxt.wdog = s_r.wdog + 10'h001;
            s_nxt.hold_seen = s_r.hold_seen || !peer.peer_hold_n;
            // Old variant needs a full low-to-high transition of wait
            if (peer.peer_hold_n && (epp_v19_sel || s_r.hold_seen)) begin
               s_nxt.st = pp_pkg::S_IDLE;
               s_nxt.ack = 1'b1;
               s_nxt.rdata = port_data_lines_in;
            end
         end
         default: begin
            s_nxt.st = pp_pkg::S_IDLE;
         end
      endcase

      // Watchdog expiry aborts the cycle; set wins over a clear
      if (epp_busy && s_r.wdog == pp_pkg::WDOG_LAST && s_nxt.st != pp_pkg::S_IDLE) begin
         s_nxt.st = pp_pkg::S_IDLE;
         s_nxt.cycle_timeout_flag = 1'b1;
         s_nxt.ack = 1'b1;
         s_nxt.rdata = port_data_lines_in;
      end

      if (mem_we) begin
         s_nxt.wp = s_nxt.wp + 5'h01;
      end
      if (pop) begin
         s_nxt.rp = s_nxt.rp + 5'h01;
      end
      // Read data is stale for one edge after any pointer movement
      s_nxt.avail = !mem_we && !pop && (s_nxt.wp != s_nxt.rp);

      // Cable lines follow the control register outside active cycles
      s_nxt.lines.data_cycle_strobe_n = ~s_nxt.ctl[pp_pkg::CTL_STROBE_BIT];
      s_nxt.lines.cycle_direction_n = ~s_nxt.ctl[pp_pkg::CTL_AUTOFD_BIT];
      s_nxt.lines.address_cycle_strobe_n = ~s_nxt.ctl[pp_pkg::CTL_SELIN_BIT];
      s_nxt.lines.init_n = s_nxt.ctl[pp_pkg::CTL_INIT_BIT];
      if (mode == pp_pkg::MODE_SPP || mode == pp_pkg::MODE_COMPAT_DATA_FIFO) begin
         s_nxt.pd_oe = 1'b1;
      end else begin
         s_nxt.pd_oe = ~s_nxt.ctl[pp_pkg::CTL_DIR_BIT];
      end
      unique case (s_nxt.st)
         pp_pkg::S_EPP_HOLD: begin
            s_nxt.lines.cycle_direction_n = s_nxt.is_read;
            s_nxt.pd_oe = !s_nxt.is_read;
         end
         pp_pkg::S_EPP_ACT: begin
            s_nxt.lines.cycle_direction_n = s_nxt.is_read;
            s_nxt.pd_oe = !s_nxt.is_read;
            if (s_nxt.is_addr) begin
               s_nxt.lines.address_cycle_strobe_n = 1'b0;
            end else begin
               s_nxt.lines.data_cycle_strobe_n = 1'b0;
            end
         end
         pp_pkg::S_FWD_SET, pp_pkg::S_FWD_REL: begin
            s_nxt.lines.data_cycle_strobe_n = 1'b1;
            s_nxt.lines.cycle_direction_n = (mode == pp_pkg::MODE_ECP) ? !s_nxt.tag : 1'b1;
         end
         pp_pkg::S_FWD_STB: begin
            s_nxt.lines.data_cycle_strobe_n = 1'b0;
            s_nxt.lines.cycle_direction_n = (mode == pp_pkg::MODE_ECP) ? !s_nxt.tag : 1'b1;
         end
         pp_pkg::S_REV_ACK: begin
            s_nxt.lines.cycle_direction_n = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.ctl <= pp_pkg::CTL_RESET;
         s_r.mode <= pp_pkg::ECR_RESET[7:5];
         s_r.ecr_lo <= pp_pkg::ECR_RESET[4:2];
         s_r.cfgb <= pp_pkg::CFGB_RESET;
         s_r.pd_oe <= 1'b1;
         s_r.lines <= 4'hE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign io_rdata = s_r.rdata;
   assign io_ack = s_r.ack;
   assign dma_rdata = s_r.rdata;
   assign port_data_lines_out = s_r.pd;
   assign port_data_lines_oe = s_r.pd_oe;
   assign lines = s_r.lines;
endmodule : epp_ecp_parallel_port
`default_nettype wire

// ---- core/pp_pkg.sv ----
// Shared constants, types and register map of the parallel port controller.
`default_nettype none
package pp_pkg;
   // ----------------------------------------------------------------
   // Register offsets relative to the I/O base
   // ----------------------------------------------------------------
   localparam logic [15:0] OFF_DATA = 16'h0000;
   localparam logic [15:0] OFF_STATUS = 16'h0001;
   localparam logic [15:0] OFF_CONTROL = 16'h0002;
   localparam logic [15:0] OFF_EPP_ADDR = 16'h0003;
   localparam logic [15:0] OFF_EPP_DATA0 = 16'h0004;
   localparam logic [15:0] OFF_EPP_DATA3 = 16'h0007;
   localparam logic [15:0] OFF_FIFO = 16'h0400;
   localparam logic [15:0] OFF_CFGB = 16'h0401;
   localparam logic [15:0] OFF_ECR = 16'h0402;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTL_DIR_BIT = 5;
   localparam int CTL_STROBE_BIT = 0;
   localparam int CTL_AUTOFD_BIT = 1;
   localparam int CTL_INIT_BIT = 2;
   localparam int CTL_SELIN_BIT = 3;
   localparam int STAT_CYCLE_TIMEOUT_FLAG_BIT = 0;
   localparam int ECR_MODE_LSB = 5;
   localparam int CFGB_IRQ_LSB = 3;
   localparam logic [5:0] CTL_RESET = 6'h00;
   localparam logic [1:0] CTL_RSVD_READ = 2'h3;
   localparam logic [7:0] ECR_RESET = 8'h15;
   localparam logic [2:0] CFGB_RESET = 3'h0;
   localparam logic [2:0] ONES3 = 3'h7;
   localparam logic [1:0] ONES2 = 2'h3;
   localparam logic [7:0] CFGA_VALUE = 8'h10;

   // ----------------------------------------------------------------
   // Timing at a 10 ns clock
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int EPP_TIMEOUT_NS = 10000;
   localparam int EPP_TIMEOUT_CYC = EPP_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam logic [9:0] WDOG_LAST = 10'(EPP_TIMEOUT_CYC - 1);
   localparam int STB_MIN_NS = 500;
   localparam int STB_CYC = (STB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] STB_LAST = 6'(STB_CYC - 1);

   // ----------------------------------------------------------------
   // FIFO geometry: 8 data bits plus the address/command tag
   // ----------------------------------------------------------------
   localparam int FIFO_AW = 4;
   localparam int FIFO_W = 9;

   typedef enum logic [2:0] {
      MODE_SPP = 3'h0,
      MODE_BIDIR = 3'h1,
      MODE_COMPAT_DATA_FIFO = 3'h2,
      MODE_ECP = 3'h3,
      MODE_EPP = 3'h4,
      MODE_RSVD = 3'h5,
      MODE_TEST = 3'h6,
      MODE_CONFIG = 3'h7
   } mode_t;

   // Gray codes along idle -> setup -> strobe -> release; on the EPP path only idle -> hold -> active steps one bit
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_FWD_SET = 4'h1,
      S_FWD_STB = 4'h3,
      S_FWD_REL = 4'h2,
      S_EPP_HOLD = 4'h4,
      S_EPP_ACT = 4'h5,
      S_REV_ACK = 4'h8,
      S_REV_PUSH = 4'hC
   } state_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic peer_hold_n;
      logic peer_acknowledge_n;
      logic paper_error_in;
      logic select_in;
      logic peer_fault_n;
   } peer_in_t;

   typedef struct packed {
      logic data_cycle_strobe_n;
      logic cycle_direction_n;
      logic address_cycle_strobe_n;
      logic init_n;
   } lines_t;
endpackage : pp_pkg
`default_nettype wire

// ---- core/pp_fifo_mem.sv ----
// Storage of the shared 16-entry byte FIFO with a registered read port.
`default_nettype none
module pp_fifo_mem (
   // Clock
   input wire logic mclk,
   // Write port
   input wire logic we,
   input wire logic [pp_pkg::FIFO_AW-1:0] waddr,
   input wire logic [pp_pkg::FIFO_W-1:0] wdata,
   // Read port
   input wire logic [pp_pkg::FIFO_AW-1:0] raddr,
   output logic [pp_pkg::FIFO_W-1:0] rdata
);
   logic [pp_pkg::FIFO_W-1:0] mem [0:(1<<pp_pkg::FIFO_AW)-1];

   // No reset on the array; read data lags the address by one edge
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : pp_fifo_mem
`default_nettype wire

// ---- verification/peer_model.sv ----
// Behavioural peripheral on the cable: EPP wait responder and data source.
`default_nettype none
module peer_model (
   // Clock and behaviour controls
   input wire logic mclk,
   input wire logic stall,
   input wire logic slow,
   input wire logic [7:0] rd_val,
   input wire logic [3:0] stat,
   // Cable
   input wire pp_pkg::lines_t lines,
   input wire logic pd_oe,
   input wire logic [7:0] pd_out,
   output pp_pkg::peer_in_t peer,
   output logic [7:0] pd_in,
   // What the last cycle looked like
   output logic [7:0] seen_data,
   output logic seen_as,
   output logic seen_dir
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hold_n = 1'b0;
   logic [7:0] last = 8'h00;
   logic [2:0] cnt = 3'h0;
   wire logic stb = !lines.data_cycle_strobe_n || !lines.address_cycle_strobe_n;
   wire logic drv = stb && lines.cycle_direction_n;
   // Undriven lines show the inverse of the last byte, so a stale value never matches
   assign pd_in = pd_oe ? pd_out : (drv ? rd_val : ~last);
   assign peer = '{hold_n, stat[3], stat[2], stat[1], stat[0]};
   // Wait rises after a short or long delay; stall never ends the cycle
   always @(posedge mclk) begin
      if (stb) begin
         seen_data <= pd_in;
         seen_as <= !lines.address_cycle_strobe_n;
         seen_dir <= lines.cycle_direction_n;
         cnt <= cnt + 3'h1;
         if (!stall && cnt == (slow ? 3'h6 : 3'h1)) hold_n <= #1 1'b1;
      end else begin
         cnt <= 3'h0;
         hold_n <= #1 1'b0;
      end
      if (pd_oe || drv) last <= pd_in;
   end
endmodule : peer_model
`default_nettype wire

// ---- verification/epp_ecp_parallel_port_sva.sv ----
// Concurrent checks on the parallel port controller's host and cable ports.
`default_nettype none
module epp_ecp_parallel_port_sva (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Host side
   input wire pp_pkg::io_req_t io_req,
   input wire logic [15:0] io_base,
   input wire logic io_ack,
   input wire logic epp_v19_sel,
   // Cable side
   input wire logic [7:0] port_data_lines_out,
   input wire logic port_data_lines_oe,
   input wire pp_pkg::peer_in_t peer,
   input wire pp_pkg::lines_t lines
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [15:0] off;
   logic epp_acc;
   logic stb;
   logic [10:0] pend_r;
   // Access to the EPP offsets and either strobe low
   assign off = io_req.addr - io_base;
   assign epp_acc = (io_req.rd || io_req.wr) && off >= 16'h0003 && off <= 16'h0007;
   assign stb = !lines.data_cycle_strobe_n || !lines.address_cycle_strobe_n;
   // Age of an unanswered request; a stuck peer must not stall the host forever
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) pend_r <= 11'h000;
      else pend_r <= ((io_req.rd || io_req.wr) && !io_ack) ? pend_r + 11'h001 : 11'h000;
   end
   AST_ACK_PULSE: assert property (io_ack |=> !io_ack)
      else $error("ack longer than one cycle");
   AST_WDOG_BOUND: assert property (pend_r <= 11'h3F2)
      else $error("request unanswered past watchdog");
   AST_HOLDOFF: assert property ($rose(stb) && epp_acc && epp_v19_sel |-> !$past(peer.peer_hold_n))
      else $error("strobe began while wait high");
   AST_END_RISE: assert property (epp_acc && stb && $rose(peer.peer_hold_n) |=> io_ack && !stb)
      else $error("cycle did not end on wait rise");
   AST_WR_DRIVE: assert property (epp_acc && io_req.wr && stb |-> !lines.cycle_direction_n && port_data_lines_oe
      && port_data_lines_out == io_req.wdata)
      else $error("write cycle not driving");
   AST_RD_FLOAT: assert property (epp_acc && io_req.rd && stb |-> lines.cycle_direction_n && !port_data_lines_oe)
      else $error("read cycle driving");
   AST_OLD_START: assert property ($rose(epp_acc) && !epp_v19_sel && !io_ack |=> stb)
      else $error("old variant start delayed");
   AST_STB_KIND: assert property (epp_acc && stb |-> (lines.address_cycle_strobe_n == (off != 16'h0003))
      && (lines.data_cycle_strobe_n == (off == 16'h0003)))
      else $error("wrong strobe for cycle");
endmodule : epp_ecp_parallel_port_sva
bind epp_ecp_parallel_port epp_ecp_parallel_port_sva u_epp_ecp_parallel_port_sva (.mclk(mclk), .sys_rst(sys_rst),
   .io_req(io_req), .io_base(io_base), .io_ack(io_ack), .epp_v19_sel(epp_v19_sel), .peer(peer), .lines(lines),
   .port_data_lines_out(port_data_lines_out), .port_data_lines_oe(port_data_lines_oe));
`default_nettype wire

// ---- verification/epp_ecp_parallel_port_tb_top.sv ----
// Self-checking bench of the parallel port controller.
`default_nettype none
module epp_ecp_parallel_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   pp_pkg::io_req_t io_req = '0;
   logic [15:0] io_base = 16'h0378;
   logic [7:0] io_rdata, dma_rdata, pd_out, pd_in, seen_data, rdv;
   logic [7:0] rd_val = 8'h00;
   logic io_ack, dma_req, pd_oe, seen_as, seen_dir;
   logic epp_en = 1'b0;
   logic v19 = 1'b1;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic dma_ack = 1'b0;
   logic [7:0] dma_wd = 8'h00;
   pp_pkg::peer_in_t peer;
   pp_pkg::lines_t lines;
   int error_cnt = 0;
   int checks = 0;
   int n;
   epp_ecp_parallel_port u_epp_ecp_parallel_port (.mclk(mclk), .sys_rst(sys_rst), .io_req(io_req),
      .io_base(io_base), .io_rdata(io_rdata), .io_ack(io_ack), .dma_req(dma_req), .dma_ack(dma_ack),
      .dma_wdata(dma_wd), .dma_rdata(dma_rdata), .epp_option_en(epp_en), .epp_v19_sel(v19),
      .port_data_lines_in(pd_in), .port_data_lines_out(pd_out), .port_data_lines_oe(pd_oe),
      .peer(peer), .lines(lines));
   peer_model u_peer_model (.mclk(mclk), .stall(stall), .slow(slow), .rd_val(rd_val), .stat(4'hA),
      .lines(lines), .pd_oe(pd_oe), .pd_out(pd_out), .peer(peer), .pd_in(pd_in), .seen_data(seen_data),
      .seen_as(seen_as), .seen_dir(seen_dir));
   initial forever #5 mclk = ~mclk;
   task automatic results();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Request held until ack, dropped in the ack cycle, one idle edge after
   task automatic io(input logic wr, input logic [15:0] off, input logic [7:0] wd);
      n = 0;
      io_req = '{!wr, wr, io_base + off, wd};
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (io_ack !== 1'b1 && n < 1100);
      if (n >= 1100) begin
         error_cnt++;
         results();
      end
      rdv = io_rdata;
      io_req = '0;
      @(posedge mclk);
      #1;
   endtask : io
   task automatic rchk(input logic [15:0] off, input logic [7:0] exp);
      io(1'b0, off, 8'h00);
      chk(rdv, exp);
   endtask : rchk
   task automatic t_regs();
      chk({4'h0, lines}, 8'h0E);
      rchk(16'h0001, 8'hD7);
      rchk(16'h0402, 8'h15);
      rchk(16'h0002, 8'hC0);
      io(1'b1, 16'h0402, 8'hE0);
      rchk(16'h0400, 8'h10);
      rchk(16'h0401, 8'h07);
      $display("t_regs done");
   endtask : t_regs
   // Direction bit ignored in mode 000, obeyed in 001
   task automatic t_spp();
      io(1'b1, 16'h0402, 8'h00);
      io(1'b1, 16'h0002, 8'h20);
      io(1'b1, 16'h0000, 8'h3C);
      chk({7'h0, pd_oe}, 8'h01);
      chk(pd_out, 8'h3C);
      rchk(16'h0000, 8'h3C);
      io(1'b1, 16'h0402, 8'h20);
      chk({7'h0, pd_oe}, 8'h00);
      rchk(16'h0000, 8'hC3);
      io(1'b1, 16'h0002, 8'h00);
      $display("t_spp done");
   endtask : t_spp
   // All four cycle types, prompt and slow peer, then the old variant
   task automatic t_epp();
      epp_en = 1'b1;
      io(1'b1, 16'h0402, 8'h80);
      for (int i = 0; i < 4; i++) begin
         rd_val = 8'h30 + 8'(i);
         slow = i[0];
         io(!i[1], 16'h0003 + 16'(i[0]), 8'hA0 + 8'(i));
         chk({6'h0, seen_as, seen_dir}, {6'h0, !i[0], i[1]});
         chk(i[1] ? rdv : seen_data, i[1] ? 8'h30 + 8'(i) : 8'hA0 + 8'(i));
      end
      chk({4'h0, lines}, 8'h0E);
      v19 = 1'b0;
      rd_val = 8'h5A;
      rchk(16'h0004, 8'h5A);
      $display("t_epp done");
   endtask : t_epp
   // Stuck peer: abort near 1000 cycles, flag set, cleared by a one only
   task automatic t_tmo();
      v19 = 1'b1;
      rchk(16'h0001, 8'hD6);
      stall = 1'b1;
      io(1'b0, 16'h0004, 8'h00);
      chk({7'h0, n >= 1000 && n <= 1004}, 8'h01);
      stall = 1'b0;
      rchk(16'h0001, 8'hD7);
      io(1'b1, 16'h0001, 8'h00);
      rchk(16'h0001, 8'hD7);
      io(1'b1, 16'h0001, 8'h01);
      rchk(16'h0001, 8'hD6);
      $display("t_tmo done");
   endtask : t_tmo
   // Test mode fill past full keeps order; one DMA byte leaves by the compat handshake
   task automatic t_fifo();
      epp_en = 1'b0;
      rchk(16'h0004, 8'h00);
      io(1'b1, 16'h0402, 8'hC0);
      for (int i = 0; i < 17; i++) begin
         io(1'b1, 16'h0400, 8'h40 + 8'(i));
      end
      rchk(16'h0402, 8'hC2);
      rchk(16'h0400, 8'h40);
      rchk(16'h0400, 8'h41);
      io(1'b1, 16'h0402, 8'h00);
      io(1'b1, 16'h0402, 8'h48);
      chk({7'h0, dma_req}, 8'h01);
      dma_wd = 8'h96;
      dma_ack = 1'b1;
      @(posedge mclk);
      #1 dma_ack = 1'b0;
      repeat (150) @(posedge mclk);
      #1;
      chk(seen_data, 8'h96);
      chk({6'h0, seen_as, seen_dir}, 8'h01);
      rchk(16'h0402, 8'h49);
      $display("t_fifo done");
   endtask : t_fifo
   initial begin
      repeat (10) @(posedge mclk);
      #1 sys_rst = 1'b0;
      t_regs();
      t_spp();
      t_epp();
      t_tmo();
      t_fifo();
      results();
   end
endmodule : epp_ecp_parallel_port_tb_top
`default_nettype wire
